//--- rtl/pwk_params.svh
// register map, field positions and reset values of the pin wake block
`ifndef PWK_PARAMS_SVH
`define PWK_PARAMS_SVH
// register indices, byte address is four times the index
`define PWK_IDX_PU_HIGH 16'hf004
`define PWK_IDX_PU_SHARED 16'hf031
`define PWK_IDX_WAKE_CFG01 16'hf230
`define PWK_IDX_WAKE_CFG23 16'hf231
`define PWK_IDX_WAKE_PEND 16'hf232
`define PWK_IDX_WAKE_CLR 16'hf233
`define PWK_IDX_WAKE_IEN 16'hf234
`define PWK_IDX_CAP_CTRL 16'hfa2b
// reset values
`define PWK_RST_PU_HIGH 8'hf0
`define PWK_RST_PU_SHARED 8'h30
`define PWK_RST_WAKE_CFG 8'h00
`define PWK_RST_CAP_CTRL 6'h00
// capacitor pin control field positions
`define PWK_CAP_IN_LEVEL 7
`define PWK_CAP_HIGH_DRIVE 5
`define PWK_CAP_IO_SEL 4
`define PWK_CAP_CAP_SEL 3
`define PWK_CAP_IN_EN 2
`define PWK_CAP_OUT_EN 1
`define PWK_CAP_OUT_VAL 0
`endif

//--- rtl/pwk_pkg.sv
// types shared by the pin wake block
package pwk_pkg;
  // one channel nibble: source, type, interrupt enable
  typedef struct packed {
    logic [1:0] src;
    logic level;
    logic irq_en;
  } pwk_chan_s;
  // trigger source codes
  typedef enum logic [1:0] {
    PWK_SRC_0 = 2'h0,
    PWK_SRC_1 = 2'h1,
    PWK_SRC_2 = 2'h2,
    PWK_SRC_3 = 2'h3
  } pwk_src_e;
  // capacitor pin drive bundle
  typedef struct packed {
    logic out;
    logic oe;
    logic high_drive;
    logic cap_func;
  } pwk_cap_drive_s;
endpackage : pwk_pkg

//--- rtl/pwk_top.sv
// pin wake triggers, pad pull-ups and capacitor pin control behind apb
`timescale 1ns/10ps
`include "pwk_params.svh"

module pwk_top
  import pwk_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [19:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] wake_pin,
  output logic wake_irq,
  output logic [3:0] strong_pullup_enable,
  output logic [3:0] weak_pullup_enable,
  output logic [3:0] shared_pin_strong_pullup,
  output logic [3:0] shared_pin_weak_pullup,
  input wire logic cap_pin_in,
  output logic cap_pin_out,
  output logic cap_pin_oe,
  output logic high_drive_select,
  output logic cap_function_active
);

  // ****************************************************************
  // state
  // ****************************************************************
  logic [7:0] pu_high; // high pin pull-ups
  logic [7:0] pu_shared; // shared pin pull-ups
  logic [7:0] wake_cfg01; // channels 0 and 1
  logic [7:0] wake_cfg23; // channels 2 and 3
  logic [3:0] pend; // sticky pending flags
  logic [5:0] cap_ctl; // capacitor pin control, bits 5..0
  logic [31:0] rd_q; // read data captured in setup
  logic [3:0] wake_s1; // first synchroniser stage
  logic [3:0] wake_s2; // synchronised level
  logic [3:0] wake_prev; // level one cycle back
  logic cap_s1; // first synchroniser stage
  logic cap_s2; // synchronised capacitor pin
  logic [7:0] next_pu_high;
  logic [7:0] next_pu_shared;
  logic [7:0] next_wake_cfg01;
  logic [7:0] next_wake_cfg23;
  logic [3:0] next_pend;
  logic [5:0] next_cap_ctl;
  logic [31:0] next_rd_q;

  pwk_chan_s chan [4]; // per channel view
  pwk_cap_drive_s cap_drv; // capacitor pin drive
  logic [3:0] trig; // per channel trigger this cycle
  logic [3:0] chan_en; // per channel enables
  logic [3:0] clr_mask; // flags software clears now
  logic [17:0] widx; // word index of the access
  logic wr_acc; // write in access phase
  logic mapped; // address hits a register
  logic cap_in_bit; // input bit as read

  // ****************************************************************
  // channel view and trigger detection
  // ****************************************************************
  assign chan[0] = wake_cfg01[3:0];
  assign chan[1] = wake_cfg01[7:4];
  assign chan[2] = wake_cfg23[3:0];
  assign chan[3] = wake_cfg23[7:4];

  // decode each channel's source under its trigger type
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      chan_en[i] = chan[i].irq_en;
      if (!chan[i].level) begin
        case (pwk_src_e'(chan[i].src))
          PWK_SRC_0: trig[i] = wake_s2[i] & ~wake_prev[i];
          PWK_SRC_1: trig[i] = ~wake_s2[i] & wake_prev[i];
          PWK_SRC_2: trig[i] = wake_s2[i] ^ wake_prev[i];
          default: trig[i] = 1'b0; // reserved code
        endcase
      end else begin
        case (pwk_src_e'(chan[i].src))
          PWK_SRC_0: trig[i] = wake_s2[i];
          PWK_SRC_1: trig[i] = ~wake_s2[i];
          default: trig[i] = 1'b0; // reserved codes
        endcase
      end
    end
  end

  // ****************************************************************
  // apb decode
  // ****************************************************************
  assign widx = paddr[19:2];
  assign wr_acc = psel & penable & pwrite;
  assign pready = 1'b1; // zero wait state
  assign pslverr = psel & penable & ~mapped; // unmapped answer

  // address hit check
  always_comb begin
    case (widx)
      {2'h0, `PWK_IDX_PU_HIGH},
      {2'h0, `PWK_IDX_PU_SHARED},
      {2'h0, `PWK_IDX_WAKE_CFG01},
      {2'h0, `PWK_IDX_WAKE_CFG23},
      {2'h0, `PWK_IDX_WAKE_PEND},
      {2'h0, `PWK_IDX_WAKE_CLR},
      {2'h0, `PWK_IDX_WAKE_IEN},
      {2'h0, `PWK_IDX_CAP_CTRL}: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // input bit reads low unless input enable is set
  assign cap_in_bit = cap_ctl[`PWK_CAP_IN_EN] & cap_s2;

  // ****************************************************************
  // register next values
  // ****************************************************************
  always_comb begin
    next_pu_high = pu_high;
    next_pu_shared = pu_shared;
    next_wake_cfg01 = wake_cfg01;
    next_wake_cfg23 = wake_cfg23;
    next_cap_ctl = cap_ctl;
    next_rd_q = rd_q;
    clr_mask = 4'h0;
    // writes take effect in the access phase
    if (wr_acc) begin
      case (widx)
        {2'h0, `PWK_IDX_PU_HIGH}: next_pu_high = pwdata[7:0];
        {2'h0, `PWK_IDX_PU_SHARED}: next_pu_shared = pwdata[7:0];
        {2'h0, `PWK_IDX_WAKE_CFG01}: next_wake_cfg01 = pwdata[7:0];
        {2'h0, `PWK_IDX_WAKE_CFG23}: next_wake_cfg23 = pwdata[7:0];
        {2'h0, `PWK_IDX_WAKE_PEND}: clr_mask = pwdata[3:0];
        {2'h0, `PWK_IDX_WAKE_CLR}: clr_mask = pwdata[3:0];
        {2'h0, `PWK_IDX_WAKE_IEN}: begin // enable alias view
          next_wake_cfg01[0] = pwdata[0];
          next_wake_cfg01[4] = pwdata[1];
          next_wake_cfg23[0] = pwdata[2];
          next_wake_cfg23[4] = pwdata[3];
        end
        {2'h0, `PWK_IDX_CAP_CTRL}: next_cap_ctl = pwdata[5:0];
        default: ; // unmapped write ignored
      endcase
    end
    // read data is captured in the setup cycle
    if (psel & ~penable & ~pwrite) begin
      case (widx)
        {2'h0, `PWK_IDX_PU_HIGH}: next_rd_q = {24'h0, pu_high};
        {2'h0, `PWK_IDX_PU_SHARED}: next_rd_q = {24'h0, pu_shared};
        {2'h0, `PWK_IDX_WAKE_CFG01}: next_rd_q = {24'h0, wake_cfg01};
        {2'h0, `PWK_IDX_WAKE_CFG23}: next_rd_q = {24'h0, wake_cfg23};
        {2'h0, `PWK_IDX_WAKE_PEND}: next_rd_q = {28'h0, pend};
        {2'h0, `PWK_IDX_WAKE_IEN}: next_rd_q = {28'h0, chan_en};
        {2'h0, `PWK_IDX_CAP_CTRL}: begin
          next_rd_q = {24'h0, cap_in_bit, 1'b0, cap_ctl};
        end
        default: next_rd_q = 32'h0; // clear register and unmapped
      endcase
    end
    // set wins over a clear in the same cycle
    next_pend = (pend & ~clr_mask) | trig;
  end

  // ****************************************************************
  // registers and synchronisers
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pu_high <= `PWK_RST_PU_HIGH;
      pu_shared <= `PWK_RST_PU_SHARED;
      wake_cfg01 <= `PWK_RST_WAKE_CFG;
      wake_cfg23 <= `PWK_RST_WAKE_CFG;
      pend <= 4'h0;
      cap_ctl <= `PWK_RST_CAP_CTRL;
      rd_q <= 32'h0;
      wake_s1 <= 4'h0;
      wake_s2 <= 4'h0;
      wake_prev <= 4'h0;
      cap_s1 <= 1'b0;
      cap_s2 <= 1'b0;
    end else begin
      pu_high <= next_pu_high;
      pu_shared <= next_pu_shared;
      wake_cfg01 <= next_wake_cfg01;
      wake_cfg23 <= next_wake_cfg23;
      pend <= next_pend;
      cap_ctl <= next_cap_ctl;
      rd_q <= next_rd_q;
      wake_s1 <= wake_pin;
      wake_s2 <= wake_s1;
      wake_prev <= wake_s2;
      cap_s1 <= cap_pin_in;
      cap_s2 <= cap_s1;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // pin function from io select and capacitor select
  always_comb begin
    cap_drv.high_drive = cap_ctl[`PWK_CAP_HIGH_DRIVE];
    cap_drv.out = cap_ctl[`PWK_CAP_OUT_VAL];
    case (cap_ctl[`PWK_CAP_IO_SEL:`PWK_CAP_CAP_SEL])
      2'h1: begin // capacitor function
        cap_drv.cap_func = 1'b1;
        cap_drv.oe = 1'b0;
      end
      2'h2: begin // io mode
        cap_drv.cap_func = 1'b0;
        cap_drv.oe = cap_ctl[`PWK_CAP_OUT_EN];
      end
      default: begin // undefined codes leave the pin idle
        cap_drv.cap_func = 1'b0;
        cap_drv.oe = 1'b0;
      end
    endcase
  end

  assign cap_pin_out = cap_drv.out;
  assign cap_pin_oe = cap_drv.oe;
  assign high_drive_select = cap_drv.high_drive;
  assign cap_function_active = cap_drv.cap_func;
  assign prdata = rd_q;
  assign wake_irq = |(pend & chan_en);
  assign strong_pullup_enable = pu_high[7:4];
  assign weak_pullup_enable = pu_high[3:0];
  assign shared_pin_strong_pullup = pu_shared[7:4];
  assign shared_pin_weak_pullup = pu_shared[3:0];

  // ****************************************************************
  // assertions
  // ****************************************************************
  // the enable bit does not change triggering, so it is left out here
  rise_sets_flag_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    (wake_cfg01[3:1] == 3'h0 && $rose(wake_s2[0])) |=> pend[0])
    else $error("rising edge did not set flag 0");

  fall_ignored_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    (wake_cfg01[3:1] == 3'h0 && pend[0] == 1'b0 && $fell(wake_s2[0]))
      |=> !pend[0])
    else $error("falling edge set a rising-edge channel");

  low_level_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    (wake_cfg01[7:5] == 3'h3 && !wake_s2[1]) |=> pend[1])
    else $error("low level did not set flag 1");

  pin_latency_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    (wake_cfg23[3:1] == 3'h1 && wake_cfg23 == $past(wake_cfg23, 3)
      && pend[2] == 1'b0 && $past(wake_pin[2], 2) == 1'b1)
      |-> ##1 pend[2])
    else $error("high level on pin did not set flag 2");

  flag_sticky_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    (pend[3] && !wr_acc) |=> pend[3])
    else $error("pending flag dropped without a clear");

  irq_cause_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    $rose(wake_irq) |-> ($past(trig & chan_en) != 4'h0
      || $past(wr_acc)) && (pend & chan_en) != 4'h0)
    else $error("interrupt rose without an enabled trigger");

  pull_reset_a: assert property (
    @(posedge sys_clk)
    $fell(reset) |-> strong_pullup_enable == 4'hf
      && weak_pullup_enable == 4'h0
      && shared_pin_strong_pullup == 4'h3
      && shared_pin_weak_pullup == 4'h0 && !wake_irq)
    else $error("pull-up reset values wrong");

  io_drive_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    cap_pin_oe |-> !cap_function_active
      && cap_ctl[4:3] == 2'h2 && cap_ctl[1])
    else $error("capacitor pin driven outside io mode");

  input_low_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    (psel && !penable && !pwrite && !cap_ctl[2]
      && widx == {2'h0, `PWK_IDX_CAP_CTRL}) |=> prdata[7] == 1'b0)
    else $error("input bit read high while input disabled");

  high_drive_write_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    (wr_acc && widx == {2'h0, `PWK_IDX_CAP_CTRL})
      |=> high_drive_select == $past(pwdata[5]))
    else $error("high drive select not updated by write");

endmodule : pwk_top

//--- tb/pwk_pin_model.sv
// far side of the pin wake block: wake inputs and the capacitor pad
`timescale 1ns/10ps

module pwk_pin_model (
  input wire logic sys_clk,
  output logic [3:0] wake_pin,
  output logic cap_pin_in,
  input wire logic cap_pin_out,
  input wire logic cap_pin_oe
);
  logic ext_level; // level an outside source puts on the capacitor pad

  // quiet pins at power up, pad pulled high from outside
  initial begin
    wake_pin = 4'h0;
    ext_level = 1'b1;
  end

  // pins move just after a clock edge, like any board signal
  task set_pin(input int ch, input logic v);
    @(posedge sys_clk);
    wake_pin[ch] <= v;
  endtask : set_pin

  // pad shows the block's drive while enabled, else the outside level
  assign cap_pin_in = cap_pin_oe ? cap_pin_out : ext_level;
endmodule : pwk_pin_model

//--- tb/tb_top.sv
// self-checking bench of the pin wake block
`timescale 1ns/10ps
`include "pwk_params.svh"

module tb_top;
  logic sys_clk, reset, psel, penable, pwrite, pready, pslverr, err;
  logic [19:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] wake_pin, spu, wpu, sspu, swpu;
  logic wake_irq, cap_pin_in, cap_pin_out, cap_pin_oe, hds, cfa;
  logic [5:0] c; // trigger case: exp, after, before, type, source
  logic [19:0] k; // cap case: write, read back, outputs
  int miscompares, comparisons;
  // trigger cases over every source code of both trigger types
  logic [5:0] tcase [14] = '{6'h30, 6'h08, 6'h29, 6'h11, 6'h32, 6'h2a,
    6'h13, 6'h0b, 6'h34, 6'h04, 6'h2d, 6'h16, 6'h17, 6'h0e};
  // cap pin cases: {hd, oe, out, cap} in the low nibble
  logic [19:0] kcase [6] = '{20'h3333e, 20'h14940, 20'h16164,
    20'h0b0b3, 20'h07872, 20'h18180};

  pwk_top uut (.sys_clk(sys_clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wake_pin(wake_pin), .wake_irq(wake_irq), .strong_pullup_enable(spu),
    .weak_pullup_enable(wpu), .shared_pin_strong_pullup(sspu),
    .shared_pin_weak_pullup(swpu), .cap_pin_in(cap_pin_in),
    .cap_pin_out(cap_pin_out), .cap_pin_oe(cap_pin_oe),
    .high_drive_select(hds), .cap_function_active(cfa));
  pwk_pin_model pins (.sys_clk(sys_clk), .wake_pin(wake_pin),
    .cap_pin_in(cap_pin_in), .cap_pin_out(cap_pin_out),
    .cap_pin_oe(cap_pin_oe));

  // ****************
  // helper tasks
  // ****************
  task automatic report_and_stop;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick

  // one apb transfer; holds the request until pready is seen high, failing the test after 16 cycles
  task automatic apb(input logic w, input logic [15:0] idx,
                     input logic [7:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h0, wd};
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      miscompares++;
      report_and_stop();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb

  task automatic wr(input logic [15:0] idx, input logic [7:0] wd);
    apb(1'b1, idx, wd);
  endtask : wr

  task automatic rdc(input string nm, input logic [15:0] idx,
                     input logic [31:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(nm, rd, exp);
  endtask : rdc

  // free-running 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ****************
  // main sequence
  // ****************
  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 20'h0;
    pwdata = 32'h0;
    miscompares = 0;
    comparisons = 0;
    tick(2);
    reset <= 1'b0;
    tick(1);
    // reset values and pull-up outputs
    rdc("pu_high", `PWK_IDX_PU_HIGH, 32'hf0);
    rdc("pu_shared", `PWK_IDX_PU_SHARED, 32'h30);
    rdc("cfg01", `PWK_IDX_WAKE_CFG01, 32'h0);
    rdc("cfg23", `PWK_IDX_WAKE_CFG23, 32'h0);
    rdc("pend", `PWK_IDX_WAKE_PEND, 32'h0);
    rdc("cap", `PWK_IDX_CAP_CTRL, 32'h0);
    chk("pulls", {16'h0, spu, wpu, sspu, swpu}, 32'hf030);
    wr(`PWK_IDX_PU_HIGH, 8'h5a);
    wr(`PWK_IDX_PU_SHARED, 8'hc3);
    chk("pulls", {16'h0, spu, wpu, sspu, swpu}, 32'h5ac3);
    // unmapped place: read zero with an error response
    apb(1'b0, 16'h0100, 8'h00);
    chk("unmapped", {err, rd[30:0]}, 32'h80000000);
    // every trigger case on every channel
    for (int ch = 0; ch < 4; ch++) begin
      for (int i = 0; i < 14; i++) begin
        c = tcase[i];
        pins.set_pin(ch, c[3]);
        tick(4);
        wr(ch < 2 ? `PWK_IDX_WAKE_CFG01 : `PWK_IDX_WAKE_CFG23,
           {4'h0, c[1:0], c[2], 1'b1} << (4 * (ch % 2)));
        wr(`PWK_IDX_WAKE_PEND, 8'h0f);
        pins.set_pin(ch, c[4]);
        tick(4);
        rdc("pend", `PWK_IDX_WAKE_PEND, 32'(c[5]) << ch);
        chk("irq", {31'h0, wake_irq}, {31'h0, c[5]});
      end
    end
    // flag sets while masked, irq follows the enable, flag is sticky
    wr(`PWK_IDX_WAKE_CFG01, 8'h00);
    wr(`PWK_IDX_WAKE_PEND, 8'h0f);
    pins.set_pin(0, 1'b1);
    tick(4);
    chk("irq_off", {31'h0, wake_irq}, 32'h0);
    rdc("pend", `PWK_IDX_WAKE_PEND, 32'h1);
    wr(`PWK_IDX_WAKE_IEN, 8'h01);
    chk("irq_on", {31'h0, wake_irq}, 32'h1);
    pins.set_pin(0, 1'b0);
    tick(4);
    wr(`PWK_IDX_WAKE_PEND, 8'h00);
    rdc("pend", `PWK_IDX_WAKE_PEND, 32'h1);
    wr(`PWK_IDX_WAKE_CLR, 8'h01);
    rdc("pend", `PWK_IDX_WAKE_PEND, 32'h0);
    chk("irq_clr", {31'h0, wake_irq}, 32'h0);
    // capacitor pin modes, drive and input read
    for (int i = 0; i < 6; i++) begin
      k = kcase[i];
      wr(`PWK_IDX_CAP_CTRL, k[19:12]);
      tick(3);
      rdc("cap", `PWK_IDX_CAP_CTRL, {24'h0, k[11:4]});
      chk("cap_outs", {28'h0, hds, cap_pin_oe, cap_pin_out, cfa},
          {28'h0, k[3:0]});
    end
    // reset in mid-run brings the controls back to their reset values
    reset <= 1'b1;
    tick(2);
    reset <= 1'b0;
    tick(1);
    chk("pulls_rst", {16'h0, spu, wpu, sspu, swpu}, 32'hf030);
    rdc("cap_rst", `PWK_IDX_CAP_CTRL, 32'h0);
    rdc("cfg01_rst", `PWK_IDX_WAKE_CFG01, 32'h0);
    report_and_stop();
  end
endmodule : tb_top
